// File: rtl/tws_cfg.svh
// constants of the two-wire serial port: offsets, fields, reset values
//
// Function
// - two-wire and sync serial share the pins
// - sync serial control bit 5 picks owner
// - software master or hardware slave roles
// - control bit 3 selects the role
// - master drives bit 7 when enabled
// - control bit 6 sets data pin direction
// - bit 5 appears on clock pin
// - data pin latched into bit 4
// - slave reset bit holds interface reset
// - slave reports transfer direction in bit 1
// - byte done sets bit 0 flag
// - data register access clears the flag
// - own address register, resets to 55h
// - data writes send, reads return received
// - only two lines, data and clock
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
// register offsets on the core register port
`define TWS_ADDR_OFS 8'h9b
`define TWS_CTRL_OFS 8'he8
`define TWS_DATA_OFS 8'h9a
// reset values
`define TWS_ADDR_RST 8'h55
`define TWS_CTRL_RST 8'h00
`define TWS_DATA_RST 8'h00
// owner bit inside the sync serial control register
`define TWS_SPI_SEL_BIT 5
// transmit buffer geometry
`define TWS_FIFO_W 8
`define TWS_FIFO_D 8
// bit index of the acknowledge slot within a nine-bit frame
`define TWS_ACK_CNT 4'h8
`define TWS_RW_CNT 4'h7
`endif

// File: rtl/tws_pkg.sv
// types shared by the two-wire serial port
package tws_pkg;
	// control register layout, msb first
	typedef struct packed {
		logic sw_master_data_out;
		logic sw_master_data_drive_en;
		logic sw_master_clock_out;
		logic sw_master_data_in;
		logic role_select;
		logic slave_iface_reset;
		logic slave_direction_flag;
		logic byte_done_flag;
	} tws_ctrl_t;
	// one register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tws_sfr_req_t;
	// open-drain pin drive pair
	typedef struct packed {
		logic out;
		logic oe;
	} tws_pin_drv_t;
	// slave frame phase on the link clock
	typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_IDLE} tws_phase_t;
endpackage

// File: rtl/tws_port.sv
// two-wire serial port: transmit buffer and port top
`timescale 1ns/100ps
`default_nettype none
`include "tws_cfg.svh"

// plain synchronous fifo, flip-flop storage
module tws_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D]; // storage words
	logic [AW-1:0] wp_r; // write index
	logic [AW-1:0] rp_r; // read index
	logic [AW:0] cnt_r; // fill level
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;

	assign in_ready_out = (cnt_r != (AW+1)'(D));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem_r[rp_r];

	// storage has no reset: only read where the level says valid
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end

	// pointers wrap at a power-of-two depth
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= push ? AW'(wp_r + 1'b1) : wp_r;
			rp_r <= pop ? AW'(rp_r + 1'b1) : rp_r;
			cnt_r <= (AW+1)'(cnt_r + push - pop);
		end
	end
endmodule

// port top: register port, software master, hardware slave
module tws_port (
	input wire logic mclk_in, // core clock
	input wire logic rst_n_in, // async reset
	input wire logic link_clk_in, // serial clock pin as link clock
	input wire tws_pkg::tws_sfr_req_t sfr_req_in, // register access
	output logic [7:0] sfr_rdata_out, // read data
	output logic tx_space_out, // transmit buffer can take a byte
	input wire logic [7:0] sync_serial_control_in, // other port's control
	input wire logic serial_data_pin_in, // data line level
	output tws_pkg::tws_pin_drv_t serial_data_pin_out, // data drive
	input wire logic serial_clock_pin_in, // clock line level
	output tws_pkg::tws_pin_drv_t serial_clock_pin_out // clock drive
);
	import tws_pkg::*;

	// register state
	tws_ctrl_t ctrl_r; // control register
	tws_ctrl_t ctrl_nxt;
	logic [7:0] addr_r; // own slave address
	logic [7:0] rx_data_r; // last received byte
	logic [7:0] tx_hold_r; // byte waiting for the link
	logic hold_valid_r;
	// pin synchronisers: stage 1 feeds stage 2 only
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;
	logic link_run_r; // link logic out of reset
	logic start_d_r; // start seen last cycle
	// link-to-core crossings
	logic done_s1_r, done_s2_r, done_s3_r;
	logic take_s1_r, take_s2_r, take_s3_r;
	logic dir_s1_r, dir_s2_r;
	// link domain state
	tws_phase_t phase_r;
	logic [3:0] cnt_r; // bit index in nine-bit frame
	logic [7:0] sh_r; // receive shifter
	logic [7:0] rx_byte_r; // byte handed to the core
	logic matched_r; // address hit
	logic rd_r; // master reads from us
	logic done_tgl_r; // toggles per finished byte
	logic [7:0] tx_sh_r; // transmit shifter, falling edge
	logic sda_low_r; // slave pulls data low
	logic take_tgl_r; // toggles when hold byte is taken

	// register decode
	wire spi_sel = sync_serial_control_in[`TWS_SPI_SEL_BIT];
	wire master = ctrl_r.role_select;
	wire hit_ctrl = (sfr_req_in.addr == `TWS_CTRL_OFS);
	wire hit_addr = (sfr_req_in.addr == `TWS_ADDR_OFS);
	wire hit_data = (sfr_req_in.addr == `TWS_DATA_OFS);
	wire wr_ctrl = sfr_req_in.wr && hit_ctrl;
	wire wr_addr = sfr_req_in.wr && hit_addr;
	wire wr_data = sfr_req_in.wr && hit_data;
	// any touch of the data register, read included
	wire data_acc = hit_data && (sfr_req_in.wr || sfr_req_in.rd);

	// bus events from synchronised pins
	wire scl_rise = scl_s2_r && !scl_s3_r;
	wire start_ev = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
	wire stop_ev = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
	// slave off while the other port owns the pins, in master role or held by the slave reset bit
	wire slave_off = spi_sel || master || ctrl_r.slave_iface_reset;
	wire done_ev = done_s2_r ^ done_s3_r;
	wire take_ev = take_s2_r ^ take_s3_r;

	// transmit buffer feeds the hold register
	wire fifo_valid;
	wire [7:0] fifo_data;
	wire fifo_pop = !hold_valid_r || take_ev;

	tws_fifo #(
		.W(`TWS_FIFO_W),
		.D(`TWS_FIFO_D)
	) u_txq (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(wr_data),
		.in_ready_out(tx_space_out),
		.in_data_in(sfr_req_in.wdata),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);

	// control next value: software bits, hardware bits, flag
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt.sw_master_data_out = sfr_req_in.wdata[7];
			ctrl_nxt.sw_master_data_drive_en = sfr_req_in.wdata[6];
			ctrl_nxt.sw_master_clock_out = sfr_req_in.wdata[5];
			ctrl_nxt.role_select = sfr_req_in.wdata[3];
			ctrl_nxt.slave_iface_reset = sfr_req_in.wdata[2];
		end
		// input bit latched on a rising serial clock while not driving
		if (master && !ctrl_r.sw_master_data_drive_en && scl_rise) begin
			ctrl_nxt.sw_master_data_in = sda_s2_r;
		end
		ctrl_nxt.slave_direction_flag = dir_s2_r;
		// software may write the flag low; a new byte wins over any clear
		if (data_acc || (wr_ctrl && !sfr_req_in.wdata[0])) begin
			ctrl_nxt.byte_done_flag = 1'b0;
		end
		if (done_ev) begin
			ctrl_nxt.byte_done_flag = 1'b1;
		end
	end

	// core-domain registers
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_r <= `TWS_CTRL_RST;
			addr_r <= `TWS_ADDR_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			addr_r <= wr_addr ? sfr_req_in.wdata : addr_r;
		end
	end

	// received byte copied once the link says a byte is done
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_data_r <= `TWS_DATA_RST;
		end else if (done_ev && !dir_s2_r) begin
			rx_data_r <= rx_byte_r;
		end
	end

	// hold register: stays stable while the link may sample it
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_hold_r <= `TWS_DATA_RST;
			hold_valid_r <= 1'b0;
		end else if (fifo_pop) begin
			tx_hold_r <= fifo_valid ? fifo_data : tx_hold_r;
			hold_valid_r <= fifo_valid;
		end
	end

	// two-flop pin synchronisers plus an edge stage
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
			{sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
		end else begin
			{scl_s1_r, scl_s2_r, scl_s3_r} <= {serial_clock_pin_in, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_s3_r} <= {serial_data_pin_in, sda_s1_r, sda_s2_r};
		end
	end

	// link crossings: toggles and one level
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{done_s1_r, done_s2_r, done_s3_r} <= 3'h0;
			{take_s1_r, take_s2_r, take_s3_r} <= 3'h0;
			{dir_s1_r, dir_s2_r} <= 2'h0;
		end else begin
			{done_s1_r, done_s2_r, done_s3_r} <= {done_tgl_r, done_s1_r, done_s2_r};
			{take_s1_r, take_s2_r, take_s3_r} <= {take_tgl_r, take_s1_r, take_s2_r};
			{dir_s1_r, dir_s2_r} <= {rd_r && matched_r, dir_s1_r};
		end
	end

	// link run: low when idle, pulsed low on every start so that a
	// repeated start restarts the frame; the clock is low long enough
	// after a start for the release to settle before its first rise
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_run_r <= 1'b0;
			start_d_r <= 1'b0;
		end else begin
			start_d_r <= start_ev && !slave_off;
			link_run_r <= !(stop_ev || start_ev || slave_off) && (link_run_r || start_d_r);
		end
	end

	// link side, rising serial clock: sample data, count bits
	always_ff @(posedge link_clk_in or negedge link_run_r) begin
		if (!link_run_r) begin
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			phase_r <= PH_ADDR;
			matched_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == `TWS_ACK_CNT) ? 4'h0 : 4'(cnt_r + 1'b1);
			sh_r <= {sh_r[6:0], serial_data_pin_in};
			case (phase_r)
				PH_ADDR: begin
					// seven address bits then the read/write bit
					if (cnt_r == `TWS_RW_CNT) begin
						matched_r <= (sh_r[6:0] == addr_r[6:0]);
						rd_r <= serial_data_pin_in;
					end
					if (cnt_r == `TWS_ACK_CNT) begin
						phase_r <= matched_r ? PH_DATA : PH_IDLE;
					end
				end
				PH_DATA: begin
					// a not-acknowledge from the master ends our sending
					if (rd_r && cnt_r == `TWS_ACK_CNT && serial_data_pin_in) begin
						phase_r <= PH_IDLE;
					end
				end
				PH_IDLE: begin
					phase_r <= PH_IDLE; // ignore the rest of the frame
				end
				default: begin
					phase_r <= PH_IDLE;
				end
			endcase
		end
	end

	// link side, byte completion: a toggle is safe while bytes end more than three core clocks apart
	always_ff @(posedge link_clk_in or negedge link_run_r) begin
		if (!link_run_r) begin
			rx_byte_r <= 8'h00;
		end else if (phase_r == PH_DATA && !rd_r && cnt_r == `TWS_RW_CNT) begin
			rx_byte_r <= {sh_r[6:0], serial_data_pin_in};
		end
	end

	// toggles survive link reset so the core never sees a false event
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_tgl_r <= 1'b0;
		end else if (link_run_r && phase_r == PH_DATA) begin
			if ((!rd_r && cnt_r == `TWS_RW_CNT) || (rd_r && cnt_r == `TWS_ACK_CNT)) begin
				done_tgl_r <= !done_tgl_r;
			end
		end
	end

	// link side, falling serial clock: drive acknowledge and send data
	wire ack_slot = (cnt_r == `TWS_ACK_CNT) &&
		((phase_r == PH_ADDR && matched_r) || (phase_r == PH_DATA && !rd_r));
	wire send = (phase_r == PH_DATA) && rd_r && (cnt_r != `TWS_ACK_CNT);
	always_ff @(negedge link_clk_in or negedge link_run_r) begin
		if (!link_run_r) begin
			tx_sh_r <= 8'h00;
			sda_low_r <= 1'b0;
		end else if (ack_slot) begin
			sda_low_r <= 1'b1;
		end else if (send && cnt_r == 4'h0) begin
			// an empty hold register resends its last byte
			tx_sh_r <= {tx_hold_r[6:0], 1'b0};
			sda_low_r <= !tx_hold_r[7];
		end else if (send) begin
			tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			sda_low_r <= !tx_sh_r[7];
		end else begin
			sda_low_r <= 1'b0;
		end
	end

	// taken-byte toggle, falling edge, outside link reset
	always_ff @(negedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			take_tgl_r <= 1'b0;
		end else if (link_run_r && send && cnt_r == 4'h0) begin
			take_tgl_r <= !take_tgl_r;
		end
	end

	// open-drain pins: level is always low, only the enable moves
	wire m_sda_low = ctrl_r.sw_master_data_drive_en && !ctrl_r.sw_master_data_out;
	assign serial_data_pin_out.out = 1'b0;
	assign serial_data_pin_out.oe = !spi_sel && (master ? m_sda_low : sda_low_r);
	assign serial_clock_pin_out.out = 1'b0;
	assign serial_clock_pin_out.oe = !spi_sel && master && !ctrl_r.sw_master_clock_out;

	// read data mux
	assign sfr_rdata_out = hit_ctrl ? ctrl_r : hit_addr ? addr_r : hit_data ? rx_data_r : 8'h00;

	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_spi_owns_pins: assert property (
		spi_sel |-> !serial_data_pin_out.oe && !serial_clock_pin_out.oe)
		else $error("pins driven while other port owns them");
	a_owner_bit_kills: assert property ($rose(spi_sel) |=> !link_run_r)
		else $error("slave kept running after owner change");
	a_master_clock_pin: assert property (
		wr_ctrl && sfr_req_in.wdata[3] && !sfr_req_in.wdata[5] && !spi_sel |=> serial_clock_pin_out.oe)
		else $error("written clock level not on pin");
	a_master_data_pin: assert property (
		wr_ctrl && sfr_req_in.wdata[3] && sfr_req_in.wdata[6] && !sfr_req_in.wdata[7] && !spi_sel
		|=> serial_data_pin_out.oe)
		else $error("data bit not driven");
	a_master_data_rx: assert property (
		master && !ctrl_r.sw_master_data_drive_en |-> !serial_data_pin_out.oe)
		else $error("data pin driven in receive direction");
	a_data_in_latch: assert property (
		master && !ctrl_r.sw_master_data_drive_en && scl_rise && !wr_ctrl
		|=> ctrl_r.sw_master_data_in == $past(sda_s2_r))
		else $error("input bit not latched");
	a_reset_holds_link: assert property (ctrl_r.slave_iface_reset |=> !link_run_r [*2])
		else $error("link ran while held in reset");
	a_flag_set: assert property (done_ev |=> ctrl_r.byte_done_flag)
		else $error("byte done flag not set");
	a_flag_clear: assert property (data_acc && !done_ev |=> !ctrl_r.byte_done_flag)
		else $error("data access left flag set");
	a_addr_write: assert property (wr_addr |=> addr_r == $past(sfr_req_in.wdata))
		else $error("address register not written");
	a_dir_follow: assert property (
		$changed(dir_s2_r) |=> ctrl_r.slave_direction_flag == $past(dir_s2_r))
		else $error("direction flag stale");
endmodule
`default_nettype wire

// File: verification/tws_bus_master.sv
// far side model: an external two-wire master that paces the link clock
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
	input wire logic sda_in, // resolved data wire
	input wire logic scl_in, // resolved clock wire, waited on after release
	output logic sda_oe_out, // high pulls data low
	output logic scl_oe_out // high pulls clock low
);
	int stall = 0; // extra low time in ns, models a slow master
	// lines start released; the pull-up then gives the idle level
	initial begin
		sda_oe_out = 1'b0;
		scl_oe_out = 1'b0;
	end
	// one bit: pull clock low, set data, release clock, sample late in high
	// only ever pulls low or lets go, never drives high
	task automatic bit_io(input logic v, output logic s);
		scl_oe_out = 1'b1;
		#31.2 sda_oe_out = !v;
		#(31.3 + stall) scl_oe_out = 1'b0;
		// a slave holding the clock low stretches the high phase start
		wait (scl_in === 1'b1);
		#62.5 s = sda_in;
	endtask
	// start: data falls while clock high, clock held high long after
	task automatic start_frame();
		sda_oe_out = 1'b0;
		scl_oe_out = 1'b0;
		#125 sda_oe_out = 1'b1;
		#300;
	endtask
	// stop: data rises while clock high; clock then stands high
	task automatic stop_frame();
		scl_oe_out = 1'b1;
		#31.2 sda_oe_out = 1'b1;
		#31.3 scl_oe_out = 1'b0;
		#62.5 sda_oe_out = 1'b0;
		#250;
	endtask
	// msb first, then release data so the slave may acknowledge
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, ack);
	endtask
	// read msb first, then acknowledge (low) or not
	task automatic get_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(!ack, s);
	endtask
endmodule
`default_nettype wire

// File: verification/two_wire_serial_port_tb_top.sv
// bench for the two-wire serial port against a queue model
`timescale 1ns/100ps
`default_nettype none
`include "tws_cfg.svh"
module two_wire_serial_port_tb_top;
	import tws_pkg::*;
	logic mclk; // core clock
	logic rst_n; // async reset
	tws_sfr_req_t req; // register access
	logic [7:0] rdata; // read data
	logic tx_space; // buffer can take a byte
	logic [7:0] ssc; // other port's control
	tws_pin_drv_t d_drv; // port data drive
	tws_pin_drv_t c_drv; // port clock drive
	logic m_sda_oe; // master data pull
	logic m_scl_oe; // master clock pull
	logic sda_w; // resolved data wire with pull-up
	logic scl_w; // resolved clock wire with pull-up
	int miscompares;
	int n_compared;
	int cycles;
	logic [7:0] lfsr; // random source
	logic [7:0] txq[$]; // bytes the port should send
	assign sda_w = !(d_drv.oe | m_sda_oe);
	assign scl_w = !(c_drv.oe | m_scl_oe);
	tws_port u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .link_clk_in(scl_w), .sfr_req_in(req),
		.sfr_rdata_out(rdata), .tx_space_out(tx_space), .sync_serial_control_in(ssc),
		.serial_data_pin_in(sda_w), .serial_data_pin_out(d_drv),
		.serial_clock_pin_in(scl_w), .serial_clock_pin_out(c_drv));
	tws_bus_master u_m (.sda_in(sda_w), .scl_in(scl_w), .sda_oe_out(m_sda_oe),
		.scl_oe_out(m_scl_oe));
	// 25 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one access pulse; read data taken at the edge that takes the access
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge mclk);
		req = '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge mclk);
		q = rdata;
		@(negedge mclk);
		req = '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		sfr(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] q;
		sfr(1'b0, a, 8'h00, q);
		check(n, q & m, e);
	endtask
	task automatic frame_ack(input logic [7:0] a, input logic e, input logic close);
		logic ack;
		u_m.start_frame();
		u_m.put_byte(a, ack);
		check("addr_ack", {7'h00, ack}, {7'h00, e});
		if (close) begin
			u_m.stop_frame();
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// a hang counts as a failure
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		logic [7:0] got;
		logic ack;
		int n;
		rst_n = 1'b0;
		req = '0;
		ssc = 8'h00;
		miscompares = 0;
		n_compared = 0;
		cycles = 0;
		lfsr = 8'h18;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		rd_chk("ctrl_rst", `TWS_CTRL_OFS, 8'hff, 8'h00);
		rd_chk("addr_rst", `TWS_ADDR_OFS, 8'hff, 8'h55);
		rd_chk("unmapped", 8'h9c, 8'hff, 8'h00);
		check("space_rst", {7'h00, tx_space}, 8'h01);
		$display("test reset done");
		// every mix of data value, data enable and clock value
		for (int i = 0; i < 8; i++) begin
			wr(`TWS_CTRL_OFS, {i[2:0], 5'h08});
			check("scl_oe", {7'h00, c_drv.oe}, {7'h00, !i[0]});
			check("sda_oe", {7'h00, d_drv.oe}, {7'h00, i[1] & !i[2]});
		end
		// data level latched on a rising clock while not driving
		for (int d = 0; d < 2; d++) begin
			u_m.sda_oe_out = !d[0];
			wr(`TWS_CTRL_OFS, 8'h08);
			wr(`TWS_CTRL_OFS, 8'h28);
			repeat (5) @(negedge mclk);
			rd_chk("sw_in", `TWS_CTRL_OFS, 8'h10, {3'h0, d[0], 4'h0});
		end
		u_m.sda_oe_out = 1'b0;
		// the other port owns the pins: nothing may be driven
		ssc = 8'h20;
		wr(`TWS_CTRL_OFS, 8'h48);
		check("owner", {6'h00, c_drv.oe, d_drv.oe}, 8'h00);
		check("pin_lvl", {6'h00, c_drv.out, d_drv.out}, 8'h00);
		wr(`TWS_CTRL_OFS, 8'h00);
		frame_ack(8'haa, 1'b1, 1'b1);
		@(negedge mclk);
		ssc = 8'h00;
		$display("test master done");
		// receive one random byte
		lfsr = lfsr_next(lfsr);
		frame_ack(8'haa, 1'b0, 1'b0);
		rd_chk("dir_rx", `TWS_CTRL_OFS, 8'h02, 8'h00);
		u_m.put_byte(lfsr, ack);
		check("data_ack", {7'h00, ack}, 8'h00);
		u_m.stop_frame();
		rd_chk("flag_rx", `TWS_CTRL_OFS, 8'h01, 8'h01);
		rd_chk("rx_byte", `TWS_DATA_OFS, 8'hff, lfsr);
		rd_chk("flag_clr", `TWS_CTRL_OFS, 8'h01, 8'h00);
		$display("test receive done");
		// fill the buffer until it refuses, then drain it with a slow master
		n = 0;
		while (tx_space === 1'b1 && n < 12) begin
			lfsr = lfsr_next(lfsr);
			txq.push_back(lfsr);
			wr(`TWS_DATA_OFS, lfsr);
			n++;
		end
		check("fill", {7'h00, n >= 8 && n < 12}, 8'h01);
		wr(`TWS_DATA_OFS, 8'h00);
		u_m.stall = 400;
		frame_ack(8'hab, 1'b0, 1'b0);
		rd_chk("dir_tx", `TWS_CTRL_OFS, 8'h02, 8'h02);
		while (txq.size() > 0) begin
			n = txq.pop_front();
			u_m.get_byte(got, txq.size() > 0);
			check("tx_byte", got, n[7:0]);
		end
		u_m.stop_frame();
		u_m.stall = 0;
		rd_chk("flag_tx", `TWS_CTRL_OFS, 8'h01, 8'h01);
		wr(`TWS_CTRL_OFS, 8'h01);
		rd_chk("flag_wr1", `TWS_CTRL_OFS, 8'h01, 8'h01);
		wr(`TWS_CTRL_OFS, 8'h00);
		rd_chk("flag_wr0", `TWS_CTRL_OFS, 8'h01, 8'h00);
		check("space_back", {7'h00, tx_space}, 8'h01);
		$display("test transmit done");
		// a new own address, then reset bit and master role silence the slave
		wr(`TWS_ADDR_OFS, 8'h2a);
		rd_chk("addr_rw", `TWS_ADDR_OFS, 8'hff, 8'h2a);
		frame_ack(8'haa, 1'b1, 1'b1);
		frame_ack(8'h54, 1'b0, 1'b1);
		wr(`TWS_ADDR_OFS, 8'h55);
		wr(`TWS_CTRL_OFS, 8'h04);
		frame_ack(8'haa, 1'b1, 1'b1);
		wr(`TWS_CTRL_OFS, 8'h28);
		frame_ack(8'haa, 1'b1, 1'b1);
		wr(`TWS_CTRL_OFS, 8'h00);
		frame_ack(8'haa, 1'b0, 1'b1);
		$display("test address done");
		report_and_stop();
	end
endmodule
`default_nettype wire
